// ==== src/ricp_pkg.sv ====
// Constants shared by the regulator control port device end and its bus master end.
// Assumes a single 100 MHz clock on both ends.
package ricp_pkg;
    // Device address upper bits; the two low bits are the variant bits.
    localparam logic [4:0]  DEV_ADDR_HI   = 5'h1C;
    localparam logic [7:0]  REG_FAULT     = 8'h00;
    localparam logic [7:0]  REG_VSEL      = 8'h01;
    localparam logic [7:0]  REG_CONTROL_ONE     = 8'h02;
    localparam logic [7:0]  REG_ID        = 8'h03;
    localparam logic [7:0]  REG_CONTROL_TWO     = 8'h04;
    localparam int          FLT_OC_BIT    = 2;
    localparam int          FLT_OT_BIT    = 1;
    localparam int          FLT_UV_BIT    = 0;
    localparam int          VSEL_EN_BIT   = 7;
    localparam int          C1_PGDLY_BIT  = 4;
    localparam int          C1_PSM_BIT    = 0;
    localparam int          C2_GO_BIT     = 5;
    localparam int          C2_DIS_BIT    = 4;
    localparam int          C2_REGOK_BIT  = 3;
    localparam int          C2_SLEW_LSB   = 1;
    localparam logic [2:0]  FAULT_RST     = 3'h0;
    localparam logic        VSEL_EN_RST   = 1'b1;
    localparam logic [7:0]  CONTROL_ONE_RST     = 8'h2F;
    localparam logic [7:0]  CONTROL_ONE_WMASK   = 8'h11;
    localparam logic [7:0]  CONTROL_TWO_RST     = 8'h02;
    localparam logic [7:0]  CONTROL_TWO_WMASK   = 8'h36;
    // Reference target in sixteenths of a millivolt: 0.6 V plus 4.6875 mV per code.
    localparam logic [15:0] REF_BASE      = 16'h2580;
    localparam logic [15:0] REF_STEP      = 16'h004B;
    localparam int          CLK_MHZ       = 100;
    localparam int          PG_DELAY_MS   = 45;
    localparam int          PG_DELAY_CYC  = PG_DELAY_MS * 1000 * CLK_MHZ;
    // Host side: own register map and serial clock quarter period.
    localparam logic [11:0] APB_CMD       = 12'h000;
    localparam logic [11:0] APB_STAT      = 12'h004;
    localparam logic [11:0] APB_ADDR      = 12'h008;
    localparam logic [6:0]  HOST_ADDR_RST = 7'h70;
    localparam int          SCL_QTR_NS    = 100;
    localparam int          QTR_CYC       = SCL_QTR_NS * CLK_MHZ / 1000;
endpackage

// ==== src/ricp_if.sv ====
// Two-wire link between the bus master end and the regulator port end.
// Both lines are open drain with an implied pull-up; levels are resolved here.
interface ricp_if;
    logic scl_h_o;
    logic scl_h_oe;
    logic sda_h_o;
    logic sda_h_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic scl;
    logic sda;

    assign scl = !(scl_h_oe && !scl_h_o);
    assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));

    modport dev (input scl, input sda, output sda_d_o, output sda_d_oe);
    modport host (input scl, input sda, output scl_h_o, output scl_h_oe,
                  output sda_h_o, output sda_h_oe);
endinterface

// ==== src/ricp_device.sv ====
// Regulator control port: two-wire slave and its five-register control bank.
// Assumes the link lines come from another clock domain and fault events,
// the raw power-good level and the regulation status come from mclk logic.
//
// Register access over the two-wire link was chosen for this implementation.
module ricp_device #(
    parameter logic [1:0]  ADDRESS_VARIANT = 2'h0,
    parameter logic [1:0]  OUT_DEFAULT     = 2'h3,
    parameter logic [6:0]  VCODE_DEFAULT   = 7'h40,
    // Arbitrary maker code.
    parameter logic [3:0]  MAKER_CODE      = 4'h5,
    parameter int          PG_DELAY        = ricp_pkg::PG_DELAY_CYC
) (
    input  wire logic        mclk,
    input  wire logic        reset,
    ricp_if.dev              bus,
    input  wire logic        overcurrent_evt,
    input  wire logic        overtemp_evt,
    input  wire logic        undervoltage_evt,
    input  wire logic        power_good_raw,
    input  wire logic        regulation_ok,
    output logic             regulator_enable,
    output logic [6:0]       voltage_code,
    output logic [15:0]      ref_target,
    output logic             pulse_skip_operation,
    output logic             power_good_delay_select,
    output logic             power_good_output,
    output logic             discharge_enable,
    output logic [1:0]       slew_code,
    output logic             transition_start,
    output logic [2:0]       fault_flags
);
    import ricp_pkg::*;

    typedef enum logic [2:0] {
        D_IDLE = 3'h0,
        D_ADDR = 3'h1,
        D_REG  = 3'h3,
        D_DATA = 3'h2,
        D_FULL = 3'h6,
        D_SKIP = 3'h4,
        D_TX   = 3'h5
    } ricp_dst_t;

    typedef struct packed {
        logic [2:0]  scl_s;
        logic [2:0]  sda_s;
        ricp_dst_t   st;
        logic [3:0]  bcnt;
        logic        in_ack;
        logic        own_ack;
        logic [7:0]  sr;
        logic [7:0]  tx;
        logic [7:0]  ptr;
        logic [7:0]  wbuf;
        logic        pend;
        logic        oe;
        logic [2:0]  flags;
        logic [7:0]  vsel;
        logic [7:0]  control_one;
        logic [7:0]  control_two;
        logic        go;
        logic [22:0] pgcnt;
        logic        pg;
        logic [15:0] ref_t;
    } ricp_dev_t;

    ricp_dev_t q_ff;
    ricp_dev_t nxt_q;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic [2:0] events;

    // Only the second and third stages are looked at; the first is a pure synchroniser.
    assign scl_rise   = q_ff.scl_s[1] && !q_ff.scl_s[2];
    assign scl_fall   = !q_ff.scl_s[1] && q_ff.scl_s[2];
    assign start_seen = q_ff.scl_s[1] && q_ff.scl_s[2] && !q_ff.sda_s[1] && q_ff.sda_s[2];
    assign stop_seen  = q_ff.scl_s[1] && q_ff.scl_s[2] && q_ff.sda_s[1] && !q_ff.sda_s[2];
    assign events     = {overcurrent_evt, overtemp_evt, undervoltage_evt};

    function automatic logic [7:0] reg_read(input logic [7:0] sel, input ricp_dev_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (sel)
            REG_FAULT: v = {5'h00, s.flags};
            REG_VSEL:  v = s.vsel;
            REG_CONTROL_ONE: v = s.control_one;
            REG_ID:    v = {MAKER_CODE, ADDRESS_VARIANT, OUT_DEFAULT};
            REG_CONTROL_TWO: v = {s.control_two[7:4], regulation_ok, s.control_two[2:0]};
            default:   v = 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        logic [2:0] clr;
        clr = 3'h0;
        nxt_q = q_ff;
        // 100 MHz oversampling leaves margin even at the shortest high period.
        nxt_q.scl_s = {q_ff.scl_s[1:0], bus.scl};
        nxt_q.sda_s = {q_ff.sda_s[1:0], bus.sda};
        nxt_q.go = 1'b0;

        if (start_seen) begin
            // A repeated start discards any uncommitted write.
            nxt_q.st = D_ADDR;
            nxt_q.bcnt = 4'h0;
            nxt_q.in_ack = 1'b0;
            nxt_q.oe = 1'b0;
            nxt_q.pend = 1'b0;
        end else if (stop_seen) begin
            nxt_q.st = D_IDLE;
            nxt_q.oe = 1'b0;
            nxt_q.pend = 1'b0;
            if (q_ff.pend) begin
                unique case (q_ff.ptr)
                    REG_FAULT: clr = q_ff.wbuf[2:0];
                    REG_VSEL:  nxt_q.vsel = q_ff.wbuf;
                    REG_CONTROL_ONE: nxt_q.control_one = (q_ff.control_one & ~CONTROL_ONE_WMASK)
                                           | (q_ff.wbuf & CONTROL_ONE_WMASK);
                    REG_CONTROL_TWO: begin
                        nxt_q.control_two = (q_ff.control_two & ~CONTROL_TWO_WMASK)
                                    | (q_ff.wbuf & CONTROL_TWO_WMASK);
                        nxt_q.go = q_ff.wbuf[C2_GO_BIT];
                    end
                    default: clr = 3'h0;
                endcase
            end
        end else if (q_ff.st == D_IDLE || q_ff.st == D_SKIP) begin
            nxt_q.oe = 1'b0;
        end else if (scl_rise) begin
            if (!q_ff.in_ack) begin
                if (q_ff.bcnt < 4'h8) begin
                    nxt_q.sr = {q_ff.sr[6:0], q_ff.sda_s[1]};
                    nxt_q.bcnt = q_ff.bcnt + 4'h1;
                end
            end else if (q_ff.st == D_TX && !q_ff.own_ack) begin
                if (q_ff.sda_s[1]) begin
                    nxt_q.st = D_SKIP;
                end else begin
                    nxt_q.ptr = q_ff.ptr + 8'h01;
                    nxt_q.tx = reg_read(q_ff.ptr + 8'h01, q_ff);
                end
            end
        end else if (scl_fall) begin
            if (q_ff.in_ack) begin
                nxt_q.in_ack = 1'b0;
                nxt_q.bcnt = 4'h0;
                nxt_q.oe = (q_ff.st == D_TX) && !q_ff.tx[7];
            end else if (q_ff.bcnt < 4'h8) begin
                if (q_ff.st == D_TX && q_ff.bcnt != 4'h0) begin
                    nxt_q.oe = !q_ff.tx[3'(4'h7 - q_ff.bcnt)];
                end
            end else begin
                nxt_q.in_ack = 1'b1;
                nxt_q.own_ack = 1'b1;
                nxt_q.oe = 1'b0;
                unique case (q_ff.st)
                    D_ADDR: begin
                        if (q_ff.sr[7:1] == {DEV_ADDR_HI, ADDRESS_VARIANT}) begin
                            nxt_q.oe = 1'b1;
                            if (q_ff.sr[0]) begin
                                nxt_q.st = D_TX;
                                nxt_q.tx = reg_read(q_ff.ptr, q_ff);
                            end else begin
                                nxt_q.st = D_REG;
                            end
                        end else begin
                            nxt_q.st = D_SKIP;
                        end
                    end
                    D_REG: begin
                        nxt_q.ptr = q_ff.sr;
                        nxt_q.oe = 1'b1;
                        nxt_q.st = D_DATA;
                    end
                    D_DATA: begin
                        nxt_q.wbuf = q_ff.sr;
                        nxt_q.pend = 1'b1;
                        nxt_q.oe = 1'b1;
                        nxt_q.st = D_FULL;
                    end
                    D_FULL: nxt_q.oe = 1'b0;
                    D_TX:   nxt_q.own_ack = 1'b0;
                    D_IDLE: nxt_q.oe = 1'b0;
                    D_SKIP: nxt_q.oe = 1'b0;
                    default: nxt_q.st = D_IDLE;
                endcase
            end
        end

        // Set wins over a clear written in the same cycle.
        nxt_q.flags = (q_ff.flags & ~clr) | events;

        // Power-good delay: the raw level must hold for the whole delay when selected.
        if (!power_good_raw) begin
            nxt_q.pgcnt = 23'h0;
            nxt_q.pg = 1'b0;
        end else if (!q_ff.control_one[C1_PGDLY_BIT]) begin
            nxt_q.pg = 1'b1;
        end else if (q_ff.pgcnt >= 23'(PG_DELAY - 1)) begin
            nxt_q.pg = 1'b1;
        end else begin
            nxt_q.pgcnt = q_ff.pgcnt + 23'h1;
        end

        nxt_q.ref_t = REF_BASE + 16'(q_ff.vsel[6:0]) * REF_STEP;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q_ff <= '0;
            q_ff.scl_s <= 3'h7;
            q_ff.sda_s <= 3'h7;
            q_ff.st <= D_IDLE;
            q_ff.flags <= FAULT_RST;
            q_ff.vsel <= {VSEL_EN_RST, VCODE_DEFAULT};
            q_ff.control_one <= CONTROL_ONE_RST;
            q_ff.control_two <= CONTROL_TWO_RST;
            q_ff.ref_t <= REF_BASE;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign bus.sda_d_o = 1'b0;
    assign bus.sda_d_oe = q_ff.oe;
    assign regulator_enable = q_ff.vsel[VSEL_EN_BIT];
    assign voltage_code = q_ff.vsel[6:0];
    assign ref_target = q_ff.ref_t;
    assign pulse_skip_operation = q_ff.control_one[C1_PSM_BIT];
    assign power_good_delay_select = q_ff.control_one[C1_PGDLY_BIT];
    assign power_good_output = q_ff.pg;
    assign discharge_enable = q_ff.control_two[C2_DIS_BIT] && !q_ff.vsel[VSEL_EN_BIT];
    assign slew_code = q_ff.control_two[C2_SLEW_LSB+1:C2_SLEW_LSB];
    assign transition_start = q_ff.go;
    assign fault_flags = q_ff.flags;
endmodule

// ==== src/ricp_host.sv ====
// Bus master end: runs single-register writes and reads on the two-wire link.
// Software drives it over APB; SDA arrives from another domain and is synchronised.
module ricp_host (
    input  wire logic        mclk,
    input  wire logic        reset,
    ricp_if.host             bus,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import ricp_pkg::*;

    typedef enum logic [3:0] {
        H_IDLE   = 4'h0,
        H_START  = 4'h1,
        H_ADDRW  = 4'h3,
        H_REG    = 4'h2,
        H_DATA   = 4'h6,
        H_STOP   = 4'h7,
        H_RSTART = 4'h5,
        H_ADDRR  = 4'h4,
        H_READ   = 4'hC
    } ricp_hst_t;

    typedef struct packed {
        logic [1:0]  sda_s;
        ricp_hst_t   st;
        logic [1:0]  ph;
        logic [3:0]  bitn;
        logic [7:0]  tick;
        logic [7:0]  sh;
        logic [7:0]  regsel;
        logic [7:0]  wdata;
        logic        rd;
        logic [6:0]  dev_addr;
        logic        busy;
        logic        nack;
        logic [7:0]  rdata;
        logic        scl_low;
        logic        sda_low;
        logic [31:0] prd;
    } ricp_host_t;

    ricp_host_t q_ff;
    ricp_host_t nxt_q;

    logic wr_acc;
    logic mapped;
    logic qtick;
    logic is_tx;

    assign wr_acc = psel && penable && pwrite;
    assign mapped = paddr == APB_CMD || paddr == APB_STAT || paddr == APB_ADDR;
    assign qtick = q_ff.tick == 8'(QTR_CYC - 1);
    assign is_tx = q_ff.st == H_ADDRW || q_ff.st == H_REG || q_ff.st == H_DATA
                || q_ff.st == H_ADDRR;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.sda_s = {q_ff.sda_s[0], bus.sda};
        nxt_q.tick = qtick ? 8'h00 : q_ff.tick + 8'h01;

        if (psel && !penable && !pwrite) begin
            unique case (paddr)
                APB_STAT: nxt_q.prd = {16'h0000, q_ff.rdata, 6'h00, q_ff.nack, q_ff.busy};
                APB_ADDR: nxt_q.prd = {25'h0, q_ff.dev_addr};
                default:  nxt_q.prd = 32'h0;
            endcase
        end
        if (wr_acc && paddr == APB_ADDR) begin
            nxt_q.dev_addr = pwdata[6:0];
        end
        // A command written while busy is dropped; software polls busy first.
        if (wr_acc && paddr == APB_CMD && !q_ff.busy) begin
            nxt_q.regsel = pwdata[7:0];
            nxt_q.wdata = pwdata[15:8];
            nxt_q.rd = pwdata[16];
            nxt_q.busy = 1'b1;
            nxt_q.nack = 1'b0;
            nxt_q.st = H_START;
            nxt_q.ph = 2'h0;
            nxt_q.tick = 8'h00;
        end else if (qtick && q_ff.st != H_IDLE) begin
            nxt_q.ph = q_ff.ph + 2'h1;
            unique case (q_ff.st)
                H_START, H_RSTART: begin
                    unique case (q_ff.ph)
                        2'h0: begin
                            nxt_q.scl_low = 1'b1;
                            nxt_q.sda_low = 1'b0;
                        end
                        2'h1: nxt_q.scl_low = 1'b0;
                        2'h2: nxt_q.sda_low = 1'b1;
                        2'h3: begin
                            nxt_q.scl_low = 1'b1;
                            nxt_q.bitn = 4'h0;
                            nxt_q.st = q_ff.st == H_START ? H_ADDRW : H_ADDRR;
                            nxt_q.sh = {q_ff.dev_addr, q_ff.st == H_RSTART};
                        end
                    endcase
                end
                H_STOP: begin
                    unique case (q_ff.ph)
                        2'h0: begin
                            nxt_q.scl_low = 1'b1;
                            nxt_q.sda_low = 1'b1;
                        end
                        2'h1: nxt_q.scl_low = 1'b0;
                        2'h2: nxt_q.sda_low = 1'b0;
                        2'h3: begin
                            nxt_q.st = H_IDLE;
                            nxt_q.busy = 1'b0;
                        end
                    endcase
                end
                default: begin
                    unique case (q_ff.ph)
                        2'h0: begin
                            nxt_q.scl_low = 1'b1;
                            // MSB first; acknowledge slot of a read left high.
                            nxt_q.sda_low = is_tx && q_ff.bitn < 4'h8
                                          && !q_ff.sh[3'(4'h7 - q_ff.bitn)];
                        end
                        2'h1: nxt_q.scl_low = 1'b0;
                        2'h2: begin
                            if (q_ff.bitn == 4'h8 && is_tx) begin
                                nxt_q.nack = q_ff.sda_s[1];
                            end else if (q_ff.bitn < 4'h8 && !is_tx) begin
                                nxt_q.sh = {q_ff.sh[6:0], q_ff.sda_s[1]};
                            end
                        end
                        2'h3: begin
                            nxt_q.scl_low = 1'b1;
                            nxt_q.bitn = q_ff.bitn + 4'h1;
                            if (q_ff.bitn == 4'h8) begin
                                nxt_q.bitn = 4'h0;
                                nxt_q.sda_low = 1'b0;
                                if (q_ff.nack) begin
                                    nxt_q.st = H_STOP;
                                end else begin
                                    unique case (q_ff.st)
                                        H_ADDRW: begin
                                            nxt_q.st = H_REG;
                                            nxt_q.sh = q_ff.regsel;
                                        end
                                        H_REG: begin
                                            nxt_q.st = q_ff.rd ? H_RSTART : H_DATA;
                                            nxt_q.sh = q_ff.wdata;
                                        end
                                        H_ADDRR: nxt_q.st = H_READ;
                                        H_READ: begin
                                            nxt_q.rdata = q_ff.sh;
                                            nxt_q.st = H_STOP;
                                        end
                                        default: nxt_q.st = H_STOP;
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            q_ff <= '0;
            q_ff.sda_s <= 2'h3;
            q_ff.st <= H_IDLE;
            q_ff.dev_addr <= HOST_ADDR_RST;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign bus.scl_h_o = 1'b0;
    assign bus.scl_h_oe = q_ff.scl_low;
    assign bus.sda_h_o = 1'b0;
    assign bus.sda_h_oe = q_ff.sda_low;
    assign prdata = q_ff.prd;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
endmodule

// ==== bench/ricp_link_monitor.sv ====
// Checker of the two-wire link between the master end and the regulator port end.
// Assumes one mclk domain and a master clock made of 10-cycle quarters.
module ricp_link_monitor (
    input wire logic mclk,
    input wire logic reset,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_h_oe,
    input wire logic sda_d_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    idle_release_a: assert property ($fell(reset) |-> scl && sda && !sda_d_oe)
        else $error("link busy after reset");
    dev_edge_low_a: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl, 2))
        else $error("device moved data off clock low");
    dev_hold_a: assert property ($rose(sda_d_oe) |-> sda_d_oe [*8])
        else $error("device pull too short");
    start_host_a: assert property ($fell(sda) && scl |-> sda_h_oe ##0 !sda_d_oe [*8])
        else $error("start not by master alone");
    stop_host_a: assert property ($rose(sda) && scl |-> $fell(sda_h_oe))
        else $error("stop not by master");
    data_steady_a: assert property (scl && $past(scl) && $stable(sda_h_oe) |-> $stable(sda))
        else $error("data moved while clock high");
    scl_high_a: assert property ($rose(scl) |-> scl [*8])
        else $error("clock high too short");
    scl_low_a: assert property ($fell(scl) |-> !scl [*8])
        else $error("clock low too short");
endmodule

// ==== bench/regulator_i2c_control_port_tb.sv ====
// Bench joining the master end and the regulator port end over one link.
// Software orders go in over APB; status inputs of the port are driven here.
module regulator_i2c_control_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ricp_pkg::*;
    logic        mclk = 0;
    logic        reset = 1;
    logic        psel = 0;
    logic        penable = 0;
    logic        pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic [31:0] rdat;
    logic        pready, pslverr, rerr, oc = 0, ot = 0, uv = 0, pgr = 0, rok = 1;
    logic        en, pskip, pgsel, pgo, dis, tstart;
    logic [6:0]  vcode;
    logic [15:0] rt;
    logic [1:0]  slew;
    logic [2:0]  flags;
    logic [7:0]  dflt [5] = '{8'h00, 8'hC0, CONTROL_ONE_RST, 8'h53, CONTROL_TWO_RST | 8'h08};
    int          failures = 0;
    int          compares = 0;
    int          pulses = 0;
    ricp_if lk ();
    ricp_device #(.PG_DELAY(20)) u_ricp_device (
        .mclk(mclk), .reset(reset), .bus(lk), .overcurrent_evt(oc), .overtemp_evt(ot),
        .undervoltage_evt(uv), .power_good_raw(pgr), .regulation_ok(rok),
        .regulator_enable(en), .voltage_code(vcode), .ref_target(rt),
        .pulse_skip_operation(pskip), .power_good_delay_select(pgsel),
        .power_good_output(pgo), .discharge_enable(dis), .slew_code(slew),
        .transition_start(tstart), .fault_flags(flags));
    ricp_host u_ricp_host (
        .mclk(mclk), .reset(reset), .bus(lk), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    ricp_link_monitor u_ricp_link_monitor (
        .mclk(mclk), .reset(reset), .scl(lk.scl), .sda(lk.sda), .sda_h_oe(lk.sda_h_oe),
        .sda_d_oe(lk.sda_d_oe));
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) pulses += (tstart === 1'b1);
    task automatic end_of_test();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    // The request stands until a rising edge samples pready high; the answer is
    // taken at that same edge and only then is the request released.
    task automatic apb(logic [11:0] a, logic w, logic [31:0] wd);
        int n = 0;
        @(posedge mclk);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rdat = prdata;
        rerr = pslverr;
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1) begin
            failures++;
            end_of_test();
        end
    endtask
    task automatic run(logic [31:0] cmd);
        apb(APB_CMD, 1, cmd);
        for (int i = 0; i < 2000; i++) begin
            apb(APB_STAT, 0, 0);
            if (rdat[0] === 1'b0) return;
        end
        failures++;
        end_of_test();
    endtask
    task automatic wr(logic [7:0] r, logic [7:0] v);
        run({15'h0, 1'b0, v, r});
    endtask
    task automatic rchk(logic [7:0] r, logic [7:0] e);
        run({15'h0, 1'b1, 8'h00, r});
        chk($sformatf("reg %h", r), e, rdat[15:8]);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        reset <= 0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 5; i++) rchk(i[7:0], dflt[i]);
        wr(REG_VSEL, 8'h15);
        chk("vcode", 7'h15, vcode);
        chk("enable", 0, en);
        chk("ref", REF_BASE + REF_STEP * 16'h15, rt);
        wr(REG_CONTROL_TWO, 8'hFF);
        rchk(REG_CONTROL_TWO, 8'h3E);
        chk("discharge", 1, dis);
        chk("slew", 3, slew);
        rok <= 0;
        wr(REG_CONTROL_TWO, 8'h20);
        rchk(REG_CONTROL_TWO, 8'h20);
        chk("starts", 2, pulses);
        chk("discharge", 0, dis);
        wr(REG_ID, 8'hFF);
        rchk(REG_ID, 8'h53);
        wr(REG_CONTROL_ONE, 8'hFE);
        rchk(REG_CONTROL_ONE, 8'h3E);
        chk("pskip", 0, pskip);
        chk("pgsel", 1, pgsel);
        {oc, ot, uv} <= 3'h7;
        @(posedge mclk);
        {oc, ot, uv} <= 3'h0;
        rchk(REG_FAULT, 8'h07);
        wr(REG_FAULT, 8'h05);
        rchk(REG_FAULT, 8'h02);
        chk("flags", 3'h2, flags);
        pgr <= 1;
        repeat (10) @(negedge mclk);
        chk("power_good_output early", 0, pgo);
        repeat (15) @(negedge mclk);
        chk("power_good_output late", 1, pgo);
        apb(APB_ADDR, 1, 32'h71);
        wr(REG_VSEL, 8'h80);
        chk("nack", 1, rdat[1]);
        apb(APB_ADDR, 1, 32'h70);
        rchk(REG_VSEL, 8'h15);
        apb(12'h00C, 0, 0);
        chk("slverr", 1, rerr);
        end_of_test();
    end
endmodule
